// ==== common/icr_pkg.sv ====
package icr_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int unsigned NUM_SRC     = 32;
    localparam int unsigned SRC_IDX_W   = 5;
    localparam int unsigned DATA_W      = 32;
    localparam int unsigned ADDR_W      = 9;
    localparam int unsigned LEVEL_W     = 3;
    localparam int unsigned MODE_W      = 4;
    localparam int unsigned STACK_DEPTH = 8;
    localparam int unsigned SP_W        = 4;
    localparam int unsigned EVT_W       = 3;

    // ------------------------------------------------------------------
    // Source bit map shared by every per-source command word
    // ------------------------------------------------------------------
    localparam int unsigned FAST_SRC_BIT      = 0;
    localparam int unsigned SOFTWARE_SRC_BIT  = 1;
    localparam int unsigned SERIAL_PORT0_BIT  = 2;
    localparam int unsigned SERIAL_PORT1_BIT  = 3;
    localparam int unsigned TIMER0_BIT        = 4;
    localparam int unsigned TIMER1_BIT        = 5;
    localparam int unsigned TIMER2_BIT        = 6;
    localparam int unsigned WATCHDOG_BIT      = 7;
    localparam int unsigned PARALLEL_IO_BIT   = 8;
    localparam int unsigned EXT_PIN0_BIT      = 16;
    localparam int unsigned EXT_PIN1_BIT      = 17;
    localparam int unsigned EXT_PIN2_BIT      = 18;
    localparam logic [31:0] VALID_SRC_MASK    = 32'h0007_01ff;

    // ------------------------------------------------------------------
    // Source mode word fields
    // ------------------------------------------------------------------
    localparam int unsigned MODE_PRIO_LSB = 0;
    localparam int unsigned MODE_EDGE_BIT = 3;

    // ------------------------------------------------------------------
    // Register map, byte addresses
    // ------------------------------------------------------------------
    localparam logic [8:0] MODE_BASE       = 9'h000;
    localparam logic [8:0] VEC_BASE        = 9'h080;
    localparam logic [8:0] REGION_SIZE     = 9'h080;
    localparam logic [8:0] NORMAL_VEC_OFF  = 9'h100;
    localparam logic [8:0] FAST_VEC_OFF    = 9'h104;
    localparam logic [8:0] CURRENT_SRC_OFF = 9'h108;
    localparam logic [8:0] PENDING_OFF     = 9'h10c;
    localparam logic [8:0] MASK_OFF        = 9'h110;
    localparam logic [8:0] CORE_STAT_OFF   = 9'h114;
    localparam logic [8:0] ENABLE_OFF      = 9'h120;
    localparam logic [8:0] DISABLE_OFF     = 9'h124;
    localparam logic [8:0] CLEAR_OFF       = 9'h128;
    localparam logic [8:0] SET_OFF         = 9'h12c;
    localparam logic [8:0] EOS_OFF         = 9'h130;
    localparam logic [8:0] SPURIOUS_OFF    = 9'h134;
    localparam logic [8:0] EVT_STAT_OFF    = 9'h140;
    localparam logic [8:0] EVT_MASK_OFF    = 9'h144;

    // ------------------------------------------------------------------
    // Event bits and reset values
    // ------------------------------------------------------------------
    localparam int unsigned EVT_NORMAL_BIT   = 0;
    localparam int unsigned EVT_FAST_BIT     = 1;
    localparam int unsigned EVT_SPURIOUS_BIT = 2;
    localparam logic [31:0] SPURIOUS_RESET   = 32'h0000_0000;
    localparam logic [31:0] MASK_RESET       = 32'h0000_0000;

    typedef enum logic [1:0] {
        ICR_BUS_IDLE,
        ICR_BUS_WAIT,
        ICR_BUS_DONE
    } icr_bus_st_type;

endpackage : icr_pkg

// ==== hw/icr_vec_mem.sv ====
`timescale 1ns/1ps

module icr_vec_mem #(
    parameter int unsigned DEPTH  = 32,
    parameter int unsigned WIDTH  = 32,
    parameter int unsigned ADDR_W = 5
) (
    input  wire logic              clk_i,     // System clock
    input  wire logic              we_i,      // Write strobe
    input  wire logic [ADDR_W-1:0] waddr_i,   // Write word index
    input  wire logic [WIDTH-1:0]  wdata_i,   // Write data
    input  wire logic [ADDR_W-1:0] raddr_i,   // Read word index
    output logic      [WIDTH-1:0]  rdata_o    // Registered read data
);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [WIDTH-1:0]            rdata;
    } icr_mem_state_type;

    icr_mem_state_type r_ff;
    icr_mem_state_type nxt_r;

    // Read before write: a same-cycle read returns the old word
    always_comb begin
        nxt_r       = r_ff;
        nxt_r.rdata = r_ff.mem[raddr_i];
        if (we_i) begin
            nxt_r.mem[waddr_i] = wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        r_ff <= nxt_r;
    end

    assign rdata_o = r_ff.rdata;

endmodule : icr_vec_mem

// ==== hw/icr_prio_pick.sv ====
`timescale 1ns/1ps

module icr_prio_pick #(
    parameter int unsigned NUM_SRC   = 32,
    parameter int unsigned IDX_W     = 5,
    parameter int unsigned LEVEL_W   = 3
) (
    input  wire logic [NUM_SRC-1:0]              req_i,       // Candidates
    input  wire logic [NUM_SRC-1:0][LEVEL_W-1:0] prio_i,      // Levels
    input  wire logic                            cur_vld_i,   // Level busy
    input  wire logic [LEVEL_W-1:0]              cur_lvl_i,   // Current lvl
    output logic                                 found_o,     // Winner ok
    output logic      [IDX_W-1:0]                src_o,       // Winner idx
    output logic      [LEVEL_W-1:0]              lvl_o        // Winner lvl
);

    logic                found;
    logic [IDX_W-1:0]    src;
    logic [LEVEL_W-1:0]  lvl;

    // Ties go to the lowest source number
    always_comb begin
        found = 1'b0;
        src   = '0;
        lvl   = '0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (req_i[i] && (!found || prio_i[i] > lvl)) begin
                found = 1'b1;
                src   = IDX_W'(i);
                lvl   = prio_i[i];
            end
        end
        if (cur_vld_i && lvl <= cur_lvl_i) begin
            found = 1'b0;
        end
    end

    assign found_o = found;
    assign src_o   = src;
    assign lvl_o   = lvl;

endmodule : icr_prio_pick

// ==== hw/icr_core.sv ====
`timescale 1ns/1ps

// Summary of operation
// R1: A one written to the enable command word enables that source, zeros change nothing.
// R2: A one written to the disable command word disables that source, zeros change nothing.
// R3: A one written to the clear command word clears that source's pending bit, zeros keep it.
// R4: A one written to the set command word makes that source pending, zeros change nothing.
// R5: Command words map fast 0, software 1, serial 2-3, timers 4-6, watchdog 7, parallel 8, pins 16-18.
// R6: Any write to the end-of-service location ends the current treatment, whatever the data.
// R7: The spurious handler address is a 32-bit read/write register that resets to zero.
// R8: The enable, disable, clear, set and end-of-service locations are write-only strobes.
// R9: Mask status reads one for each enabled source and zero for disabled ones, zero after reset.
// R10: Pending status reads one while a source is pending, changed by the set and clear commands.
// R11: End of service pops the level stack and re-raises the normal request if a source now outranks it.
// R12: A normal vector read makes the best pending source current, pushes it, drops the request, auto-clears edges.
// R13: Reads of the command locations return zero and disturb no state.
module icr_core (
    input  wire logic        clk_i,                  // System clock
    input  wire logic        rst_i,                  // Sync reset, high
    input  wire logic        cyc_i,                  // Wishbone cycle
    input  wire logic        stb_i,                  // Wishbone strobe
    input  wire logic        we_i,                   // Wishbone write
    input  wire logic [8:0]  adr_i,                  // Byte address
    input  wire logic [3:0]  sel_i,                  // Byte lanes
    input  wire logic [31:0] dat_i,                  // Write data
    output logic      [31:0] dat_o,                  // Read data
    output logic             ack_o,                  // Wishbone ack
    input  wire logic [31:0] source_i,               // Source levels
    output logic             normal_request_line_o,  // To core, high
    output logic             fast_request_line_o,    // To core, high
    output logic             irq_o                   // Event interrupt
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        icr_pkg::icr_bus_st_type                                   st;
        logic                                                      ack;
        logic [icr_pkg::DATA_W-1:0]                                dat;
        logic [icr_pkg::ADDR_W-1:0]                                adr;
        logic                                                      vec_hit;
        logic [icr_pkg::NUM_SRC-1:0]                               mask;
        logic [icr_pkg::NUM_SRC-1:0]                               pend;
        logic [icr_pkg::NUM_SRC-1:0]                               prev;
        logic [icr_pkg::NUM_SRC-1:0][icr_pkg::MODE_W-1:0]          mode;
        logic [icr_pkg::DATA_W-1:0]                                spur;
        logic [icr_pkg::STACK_DEPTH-1:0][icr_pkg::LEVEL_W-1:0]     stk_lvl;
        logic [icr_pkg::STACK_DEPTH-1:0][icr_pkg::SRC_IDX_W-1:0]   stk_src;
        logic [icr_pkg::SP_W-1:0]                                  sp;
        logic                                                      normal_request_line;
        logic                                                      fast_request_line;
        logic [icr_pkg::EVT_W-1:0]                                 evt;
        logic [icr_pkg::EVT_W-1:0]                                 emask;
        logic                                                      irq;
    } icr_core_state_type;

    icr_core_state_type r_ff;
    icr_core_state_type nxt_r;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] sel_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  sel);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return res;
    endfunction : sel_merge

    function automatic logic in_region(input logic [8:0] addr,
                                       input logic [8:0] base);
        return (addr >= base) && (addr < base + icr_pkg::REGION_SIZE);
    endfunction : in_region

    function automatic logic [4:0] word_idx(input logic [8:0] addr);
        return addr[6:2];
    endfunction : word_idx

    // ------------------------------------------------------------------
    // Arbitration and vector memory
    // ------------------------------------------------------------------
    logic [icr_pkg::NUM_SRC-1:0]                      pick_req;
    logic [icr_pkg::NUM_SRC-1:0][icr_pkg::LEVEL_W-1:0] pick_prio;
    logic                                             cur_vld;
    logic [icr_pkg::LEVEL_W-1:0]                      cur_lvl;
    logic [icr_pkg::SRC_IDX_W-1:0]                    cur_src;
    logic                                             cand_found;
    logic [icr_pkg::SRC_IDX_W-1:0]                    cand_src;
    logic [icr_pkg::LEVEL_W-1:0]                      cand_lvl;
    logic                                             mem_we;
    logic [icr_pkg::SRC_IDX_W-1:0]                    mem_raddr;
    logic [icr_pkg::DATA_W-1:0]                       mem_rdata;
    logic                                             take;
    logic [icr_pkg::SRC_IDX_W-1:0]                    sp_top;

    assign take    = (r_ff.st == icr_pkg::ICR_BUS_IDLE) && cyc_i && stb_i;
    assign cur_vld = (r_ff.sp != '0);
    assign sp_top  = icr_pkg::SRC_IDX_W'(r_ff.sp[2:0] - 3'h1);
    assign cur_lvl = r_ff.stk_lvl[sp_top[2:0]];
    assign cur_src = r_ff.stk_src[sp_top[2:0]];

    // The fast source has its own line and never competes here
    always_comb begin
        pick_req = r_ff.pend & r_ff.mask & icr_pkg::VALID_SRC_MASK;
        pick_req[icr_pkg::FAST_SRC_BIT] = 1'b0;
        for (int i = 0; i < icr_pkg::NUM_SRC; i++) begin
            pick_prio[i] = r_ff.mode[i][icr_pkg::MODE_PRIO_LSB +:
                                        icr_pkg::LEVEL_W];
        end
    end

    icr_prio_pick #(
        .NUM_SRC   (icr_pkg::NUM_SRC),
        .IDX_W     (icr_pkg::SRC_IDX_W),
        .LEVEL_W   (icr_pkg::LEVEL_W)
    ) u_pick (
        .req_i     (pick_req),
        .prio_i    (pick_prio),
        .cur_vld_i (cur_vld),
        .cur_lvl_i (cur_lvl),
        .found_o   (cand_found),
        .src_o     (cand_src),
        .lvl_o     (cand_lvl)
    );

    // Vector words only take full-word writes; a partial write is dropped
    assign mem_we = take && we_i && (sel_i == 4'hf)
                    && in_region(adr_i, icr_pkg::VEC_BASE);

    always_comb begin
        mem_raddr = word_idx(adr_i);
        if (adr_i == icr_pkg::NORMAL_VEC_OFF) begin
            mem_raddr = cand_src;
        end else if (adr_i == icr_pkg::FAST_VEC_OFF) begin
            mem_raddr = icr_pkg::SRC_IDX_W'(icr_pkg::FAST_SRC_BIT);
        end
    end

    icr_vec_mem #(
        .DEPTH   (icr_pkg::NUM_SRC),
        .WIDTH   (icr_pkg::DATA_W),
        .ADDR_W  (icr_pkg::SRC_IDX_W)
    ) u_vec (
        .clk_i   (clk_i),
        .we_i    (mem_we),
        .waddr_i (word_idx(adr_i)),
        .wdata_i (dat_i),
        .raddr_i (mem_raddr),
        .rdata_o (mem_rdata)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    logic [31:0]                  rdata;
    logic [31:0]                  en_cmd;
    logic [31:0]                  dis_cmd;
    logic [31:0]                  clr_cmd;
    logic [31:0]                  set_cmd;
    logic [31:0]                  auto_clr;
    logic [31:0]                  hw_evt;
    logic [icr_pkg::EVT_W-1:0]    evt_set;
    logic [icr_pkg::EVT_W-1:0]    evt_clr;
    logic                         wr;

    always_comb begin
        nxt_r    = r_ff;
        rdata    = '0;
        en_cmd   = '0;
        dis_cmd  = '0;
        clr_cmd  = '0;
        set_cmd  = '0;
        auto_clr = '0;
        evt_set  = '0;
        evt_clr  = '0;
        wr       = take && we_i;

        // Command strobes, masked to the documented source map
        if (wr) begin
            case (adr_i)
                icr_pkg::ENABLE_OFF: begin
                    en_cmd = sel_merge('0, dat_i, sel_i);         // R1 R8
                end
                icr_pkg::DISABLE_OFF: begin
                    dis_cmd = sel_merge('0, dat_i, sel_i);        // R2 R8
                end
                icr_pkg::CLEAR_OFF: begin
                    clr_cmd = sel_merge('0, dat_i, sel_i);        // R3 R8
                end
                icr_pkg::SET_OFF: begin
                    set_cmd = sel_merge('0, dat_i, sel_i);        // R4 R8
                end
                icr_pkg::EOS_OFF: begin
                    if (cur_vld) begin
                        nxt_r.sp = r_ff.sp - 4'h1;                // R6 R11
                    end
                end
                icr_pkg::SPURIOUS_OFF: begin
                    nxt_r.spur = sel_merge(r_ff.spur, dat_i, sel_i); // R7
                end
                icr_pkg::EVT_STAT_OFF: begin
                    evt_clr = dat_i[icr_pkg::EVT_W-1:0];
                end
                icr_pkg::EVT_MASK_OFF: begin
                    nxt_r.emask = dat_i[icr_pkg::EVT_W-1:0];
                end
                default: begin
                    if (in_region(adr_i, icr_pkg::MODE_BASE)) begin
                        nxt_r.mode[word_idx(adr_i)] =
                            dat_i[icr_pkg::MODE_W-1:0];
                    end
                end
            endcase
        end

        // Vector reads carry side effects; the other reads carry none
        nxt_r.vec_hit = 1'b0;
        if (take && !we_i) begin
            if (adr_i == icr_pkg::NORMAL_VEC_OFF) begin
                if (cand_found) begin
                    nxt_r.vec_hit = 1'b1;
                    nxt_r.stk_lvl[r_ff.sp[2:0]] = cand_lvl;        // R12
                    nxt_r.stk_src[r_ff.sp[2:0]] = cand_src;        // R12
                    nxt_r.sp = r_ff.sp + 4'h1;                     // R12
                    if (r_ff.mode[cand_src][icr_pkg::MODE_EDGE_BIT]) begin
                        auto_clr[cand_src] = 1'b1;                 // R12
                    end
                end else begin
                    evt_set[icr_pkg::EVT_SPURIOUS_BIT] = 1'b1;
                end
            end else if (adr_i == icr_pkg::FAST_VEC_OFF) begin
                nxt_r.vec_hit = 1'b1;
                if (r_ff.mode[icr_pkg::FAST_SRC_BIT]
                             [icr_pkg::MODE_EDGE_BIT]) begin
                    auto_clr[icr_pkg::FAST_SRC_BIT] = 1'b1;
                end
            end else if (in_region(adr_i, icr_pkg::VEC_BASE)) begin
                nxt_r.vec_hit = 1'b1;
            end
        end

        // Source sampling: rising edge or level per source mode
        nxt_r.prev = source_i;
        for (int i = 0; i < icr_pkg::NUM_SRC; i++) begin
            hw_evt[i] = r_ff.mode[i][icr_pkg::MODE_EDGE_BIT]
                      ? (source_i[i] && !r_ff.prev[i]) : source_i[i];
        end

        // A new event wins over a clear landing in the same cycle
        nxt_r.pend = ((r_ff.pend & ~clr_cmd & ~auto_clr)
                     | set_cmd | hw_evt)
                     & icr_pkg::VALID_SRC_MASK;                    // R3 R4 R5 R10
        nxt_r.mask = ((r_ff.mask & ~dis_cmd) | en_cmd)
                     & icr_pkg::VALID_SRC_MASK;                    // R1 R2 R5 R9

        // Request lines to the core
        nxt_r.normal_request_line = cand_found;                                   // R11 R12
        nxt_r.fast_request_line = r_ff.pend[icr_pkg::FAST_SRC_BIT]
                     && r_ff.mask[icr_pkg::FAST_SRC_BIT];
        evt_set[icr_pkg::EVT_NORMAL_BIT] = nxt_r.normal_request_line && !r_ff.normal_request_line;
        evt_set[icr_pkg::EVT_FAST_BIT]   = nxt_r.fast_request_line && !r_ff.fast_request_line;
        nxt_r.evt = (r_ff.evt & ~evt_clr) | evt_set;
        nxt_r.irq = |(nxt_r.evt & nxt_r.emask);

        // Read mux; command locations fall to the zero default
        case (r_ff.adr)
            icr_pkg::NORMAL_VEC_OFF:  rdata = r_ff.spur;
            icr_pkg::CURRENT_SRC_OFF: begin
                rdata = cur_vld ? 32'(cur_src) : '0;
            end
            icr_pkg::PENDING_OFF:     rdata = r_ff.pend;           // R10
            icr_pkg::MASK_OFF:        rdata = r_ff.mask;           // R9
            icr_pkg::CORE_STAT_OFF: begin
                rdata = {30'h0, r_ff.normal_request_line, r_ff.fast_request_line};
            end
            icr_pkg::SPURIOUS_OFF:    rdata = r_ff.spur;           // R7
            icr_pkg::EVT_STAT_OFF:    rdata = 32'(r_ff.evt);
            icr_pkg::EVT_MASK_OFF:    rdata = 32'(r_ff.emask);
            default: begin
                if (in_region(r_ff.adr, icr_pkg::MODE_BASE)) begin
                    rdata = 32'(r_ff.mode[word_idx(r_ff.adr)]);
                end else begin
                    rdata = '0;                                    // R8 R13
                end
            end
        endcase

        // Bus handshake: take, answer, then drop ack
        case (r_ff.st)
            icr_pkg::ICR_BUS_IDLE: begin
                nxt_r.ack = 1'b0;
                if (take) begin
                    nxt_r.adr = adr_i;
                    nxt_r.st  = icr_pkg::ICR_BUS_WAIT;
                end
            end
            icr_pkg::ICR_BUS_WAIT: begin
                nxt_r.ack = 1'b1;
                nxt_r.dat = r_ff.vec_hit ? mem_rdata : rdata;
                nxt_r.st  = icr_pkg::ICR_BUS_DONE;
            end
            icr_pkg::ICR_BUS_DONE: begin
                nxt_r.ack = 1'b0;
                nxt_r.dat = '0;
                nxt_r.st  = icr_pkg::ICR_BUS_IDLE;
            end
            default: begin
                nxt_r.ack = 1'b0;
                nxt_r.st  = icr_pkg::ICR_BUS_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r_ff      <= '0;
            r_ff.st   <= icr_pkg::ICR_BUS_IDLE;
            r_ff.spur <= icr_pkg::SPURIOUS_RESET;                  // R7
            r_ff.mask <= icr_pkg::MASK_RESET;                      // R9
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign dat_o                 = r_ff.dat;
    assign ack_o                 = r_ff.ack;
    assign normal_request_line_o = r_ff.normal_request_line;
    assign fast_request_line_o   = r_ff.fast_request_line;
    assign irq_o                 = r_ff.irq;

endmodule : icr_core

// ==== testbench/icr_core_properties.sv ====
`timescale 1ns/1ps
module icr_chk (
    input wire logic        clk_i, rst_i, cyc_i, stb_i, we_i,
    input wire logic [8:0]  adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i, dat_o,
    input wire logic        ack_o, normal_request_line_o,
    input wire logic        fast_request_line_o, irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_take; $rose(cyc_i && stb_i); endsequence
    sequence s_wr(a); s_take ##0 (we_i && adr_i == a); endsequence
    property p_ack_lat; s_take |-> ##1 !ack_o ##1 ack_o; endproperty
    property p_ack_pulse; ack_o |=> !ack_o; endproperty
    property p_ack_req; ack_o |-> cyc_i && stb_i; endproperty
    property p_dat_idle; !ack_o |-> dat_o == 32'h0; endproperty
    property p_cmd_rd;
        s_take ##0 (!we_i && adr_i >= icr_pkg::ENABLE_OFF
            && adr_i <= icr_pkg::EOS_OFF) |-> ##2 dat_o == 32'h0;
    endproperty
    property p_nvec;
        s_take ##0 (!we_i && adr_i == icr_pkg::NORMAL_VEC_OFF)
            |-> ##2 !normal_request_line_o;
    endproperty
    property p_fast_off;
        s_wr(icr_pkg::DISABLE_OFF) ##0 (dat_i[0] && sel_i[0])
            |-> ##2 !fast_request_line_o;
    endproperty
    property p_rst;
        disable iff (1'b0) rst_i |=> !ack_o && !irq_o
            && !normal_request_line_o && !fast_request_line_o;
    endproperty
    a_ack_lat: assert property (p_ack_lat) else $error("ack late");
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack long");
    a_ack_req: assert property (p_ack_req) else $error("ack no cycle");
    a_dat_idle: assert property (p_dat_idle) else $error("dat not 0");
    a_cmd_rd: assert property (p_cmd_rd) else $error("cmd rd");
    a_nvec: assert property (p_nvec) else $error("nvec line");
    a_fast_off: assert property (p_fast_off) else $error("fast");
    a_rst: assert property (p_rst) else $error("reset outs");
endmodule : icr_chk
bind icr_core icr_chk icr_chk_i (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
    .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .normal_request_line_o,
    .fast_request_line_o, .irq_o);

// ==== testbench/icr_cpu_model.sv ====
`timescale 1ns/1ps
module icr_cpu_model (
    input  wire logic       clk_i,   // System clock
    input  wire logic       rst_i,   // Sync reset, high
    input  wire logic       nrq_i,   // Normal request line
    input  wire logic       frq_i,   // Fast request line
    output logic      [7:0] nrise_o, // Normal requests taken
    output logic      [7:0] frise_o  // Fast requests taken
);
    logic nrq_ff;
    logic frq_ff;
    always_ff @(posedge clk_i) begin
        nrq_ff  <= rst_i ? 1'b0 : nrq_i;
        frq_ff  <= rst_i ? 1'b0 : frq_i;
        nrise_o <= rst_i ? 8'h00 : nrise_o + 8'(nrq_i && !nrq_ff);
        frise_o <= rst_i ? 8'h00 : frise_o + 8'(frq_i && !frq_ff);
    end
endmodule : icr_cpu_model

// ==== testbench/testbench.sv ====
`timescale 1ns/1ps
module testbench;
    logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
    logic [8:0]  adr_i = 9'h000;
    logic [31:0] dat_i = 32'h0, dat_o, q;
    logic        ack_o, nrl, frl, irq_o;
    logic [7:0]  nrise, frise;
    int          fail_count = 0, checks = 0;
    icr_core icr_core_i (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
        .sel_i(4'hf), .dat_i, .dat_o, .ack_o, .source_i(32'h0),
        .normal_request_line_o(nrl), .fast_request_line_o(frl), .irq_o);
    icr_cpu_model icr_cpu_model_i (.clk_i, .rst_i, .nrq_i(nrl),
        .frq_i(frl), .nrise_o(nrise), .frise_o(frise));
    initial forever #4 clk_i = ~clk_i;
    task automatic chk(input string n, input logic [31:0] e, g);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [8:0] a, input logic [31:0] d, w = 1);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w[0];
        adr_i <= a;
        dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        if (n == 20) chk("ack", 32'h1, 32'h0);
    endtask : wr
    task automatic rd(input string n, input logic [8:0] a, input logic [31:0] e);
        wr(a, 32'h0, 0);
        chk(n, e, q);
    endtask : rd
    task automatic lines(input logic n, f, i);
        @(negedge clk_i);
        chk("normal", {31'h0, n}, {31'h0, nrl});
        chk("fast", {31'h0, f}, {31'h0, frl});
        chk("irq", {31'h0, i}, {31'h0, irq_o});
    endtask : lines
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : final_report
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        rd("mask", icr_pkg::MASK_OFF, 32'h0);
        rd("spur", icr_pkg::SPURIOUS_OFF, 32'h0);
        wr(icr_pkg::SPURIOUS_OFF, 32'ha5c3_0f96);
        rd("spur", icr_pkg::SPURIOUS_OFF, 32'ha5c3_0f96);
        wr(icr_pkg::ENABLE_OFF, 32'hffff_ffff);
        rd("mask", icr_pkg::MASK_OFF, icr_pkg::VALID_SRC_MASK);
        wr(icr_pkg::DISABLE_OFF, 32'h0004_0081);
        rd("mask", icr_pkg::MASK_OFF, 32'h0003_017e);
        wr(icr_pkg::ENABLE_OFF, 32'h0000_0080);
        rd("mask", icr_pkg::MASK_OFF, 32'h0003_01fe);
        $display("test mask done");
        wr(icr_pkg::VEC_BASE + 9'h010, 32'h0000_4444);
        wr(icr_pkg::SET_OFF, 32'hfffc_fe30);
        rd("pend", icr_pkg::PENDING_OFF, 32'h0004_0030);
        wr(icr_pkg::CLEAR_OFF, 32'h0000_0020);
        rd("pend", icr_pkg::PENDING_OFF, 32'h0004_0010);
        for (int a = 0; a < 5; a++)
            rd("cmd", icr_pkg::ENABLE_OFF + 9'(4 * a), 32'h0);
        rd("pend", icr_pkg::PENDING_OFF, 32'h0004_0010);
        rd("unmapped", 9'h1fc, 32'h0);
        $display("test commands done");
        lines(1'b1, 1'b0, 1'b0);
        rd("vector", icr_pkg::NORMAL_VEC_OFF, 32'h0000_4444);
        lines(1'b0, 1'b0, 1'b0);
        wr(icr_pkg::EOS_OFF, 32'hffff_ffff);
        lines(1'b1, 1'b0, 1'b0);
        chk("rises", 32'h2, {24'h0, nrise});
        $display("test service done");
        wr(icr_pkg::EVT_MASK_OFF, 32'h1);
        lines(1'b1, 1'b0, 1'b1);
        wr(icr_pkg::EVT_MASK_OFF, 32'h0);
        lines(1'b1, 1'b0, 1'b0);
        wr(icr_pkg::EVT_MASK_OFF, 32'h1);
        wr(icr_pkg::EVT_STAT_OFF, 32'h1);
        lines(1'b1, 1'b0, 1'b0);
        wr(icr_pkg::ENABLE_OFF, 32'h1);
        wr(icr_pkg::SET_OFF, 32'h1);
        lines(1'b1, 1'b1, 1'b0);
        wr(icr_pkg::DISABLE_OFF, 32'h1);
        lines(1'b1, 1'b0, 1'b0);
        chk("frise", 32'h1, {24'h0, frise});
        wr(icr_pkg::MODE_BASE + 9'h010, 32'h9);
        wr(icr_pkg::SET_OFF, 32'h20);
        rd("vector", icr_pkg::NORMAL_VEC_OFF, 32'h0000_4444);
        rd("cur", icr_pkg::CURRENT_SRC_OFF, 32'h4);
        rd("pend", icr_pkg::PENDING_OFF, 32'h0004_0021);
        wr(icr_pkg::EOS_OFF, 32'h0);
        lines(1'b1, 1'b0, 1'b1);
        $display("test events done");
        final_report();
    end
    initial begin
        repeat (3000) @(posedge clk_i);
        fail_count++;
        final_report();
    end
endmodule : testbench
